// ==== rtl/tab_pkg.sv ====
/*
 Constants for the timer A / timer B block: register map, field positions,
 reset values, read-back patterns and the operating-mode enumeration.
 Assumes a 32-bit Avalon-MM slave port with byte addresses and one clock.
*/
package tab_pkg;

   // ---------------------------------------------------------------
   // Bus and counter geometry
   // ---------------------------------------------------------------
   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;
   localparam int CNT_W  = 16;

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] A_CNT_OFS  = 5'h00;
   localparam logic [ADDR_W-1:0] A_MODE_OFS = 5'h04;
   localparam logic [ADDR_W-1:0] B_CNT_OFS  = 5'h08;
   localparam logic [ADDR_W-1:0] B_MODE_OFS = 5'h0c;
   localparam logic [ADDR_W-1:0] START_OFS  = 5'h10;
   localparam logic [ADDR_W-1:0] IRQ_ST_OFS = 5'h14;
   localparam logic [ADDR_W-1:0] IRQ_MK_OFS = 5'h18;
   localparam logic [ADDR_W-1:0] STAT_OFS   = 5'h1c;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int MODE_LSB   = 0;
   localparam int FREE_BIT   = 2;
   localparam int UP_BIT     = 3;
   localparam int B_EVT_BIT  = 0;
   localparam int START_A    = 0;
   localparam int START_B    = 1;
   localparam int IRQ_A      = 0;
   localparam int IRQ_B      = 1;
   localparam int NUM_IRQ    = 2;

   // ---------------------------------------------------------------
   // Reset values and read-back patterns
   // ---------------------------------------------------------------
   localparam logic [CNT_W-1:0]   CNT_RST     = 16'h0000;
   localparam logic [CNT_W-1:0]   RD_ONES     = 16'hffff;
   localparam logic [CNT_W-1:0]   RD_ZEROS    = 16'h0000;
   localparam logic [CNT_W-1:0]   RD_A_TMR    = 16'h0fff;
   localparam logic [NUM_IRQ-1:0] IRQ_RST     = 2'h0;
   localparam logic [DATA_W-1:0]  RD_UNMAPPED = 32'h0000_0000;

   // ---------------------------------------------------------------
   // Timer A operating modes, Gray along timer-event-oneshot-pwm
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_TMR = 2'h0,
      MODE_EVT = 2'h1,
      MODE_OSH = 2'h3,
      MODE_PWM = 2'h2
   } tab_mode_t;

endpackage

// ==== rtl/tab_cnt16.sv ====
/*
 Sixteen-bit loadable up/down counter with a wrap flag.
 Assumes the owner decides when to load; load beats step.
*/
module tab_cnt16
   import tab_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             ce,
   input  wire logic             load,
   input  wire logic [CNT_W-1:0] load_val,
   input  wire logic             step,
   input  wire logic             up,
   output logic      [CNT_W-1:0] count,
   output logic                  wrap
);

   logic [CNT_W-1:0] count_r;
   logic [CNT_W-1:0] count_nxt;
   logic [CNT_W-1:0] stepped;

   // ---------------------------------------------------------------
   // Next value
   // ---------------------------------------------------------------
   assign stepped   = up ? count_r + 16'h0001 : count_r - 16'h0001;
   assign count_nxt = load ? load_val : (step ? stepped : count_r);
   // Wrap is the cycle in which the edge value is stepped past
   assign wrap      = step & (up ? (count_r == RD_ONES) : (count_r == RD_ZEROS));
   assign count     = count_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_r <= CNT_RST;
      end else if (ce) begin
         count_r <= count_nxt;
      end
   end

endmodule

// ==== rtl/tab_timer.sv ====
/*
 Timer A (timer, event counter, one-shot, PWM) and timer B (timer, event
 counter) with read-back side effects and mode-change interrupt requests,
 behind an Avalon-MM slave with waitrequest.
 Assumes event inputs are synchronous one-cycle pulses on clk and that the
 master holds each request until it sees waitrequest low.
 Count registers need byte lanes 1:0 together; narrower writes are dropped.
*/
// Chosen here: the Avalon-MM register port and the register addresses.
module tab_timer
   import tab_pkg::*;
(
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   input  wire logic                       ce,
   input  wire logic [tab_pkg::ADDR_W-1:0] avs_address,
   input  wire logic                       avs_read,
   input  wire logic                       avs_write,
   input  wire logic [tab_pkg::DATA_W-1:0] avs_writedata,
   input  wire logic [3:0]                 avs_byteenable,
   output logic      [tab_pkg::DATA_W-1:0] avs_readdata,
   output logic                            avs_waitrequest,
   input  wire logic                       ta_event_in,
   input  wire logic                       tb_event_in,
   output logic                            timer_a_output_pin,
   output logic                            irq
);

   import tab_pkg::*;

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic                wait_r;
   logic [DATA_W-1:0]   rdata_r;
   logic                irq_r;
   tab_mode_t           mode_a_r;
   logic                free_a_r;
   logic                up_a_r;
   logic                evt_b_r;
   logic                start_a_r;
   logic                start_b_r;
   logic                os_act_r;
   logic                out_a_r;
   logic [CNT_W-1:0]    rld_a_r;
   logic [CNT_W-1:0]    rld_b_r;
   logic [NUM_IRQ-1:0]  irq_st_r;
   logic [NUM_IRQ-1:0]  irq_mk_r;

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   logic                wr_acc;
   logic                rd_cap;
   logic                be_lo;
   logic                be_cnt;
   logic                wr_a_cnt;
   logic                wr_a_mode;
   logic                wr_b_cnt;
   logic                wr_b_mode;
   logic                wr_start;
   logic                wr_irq_st;
   logic                wr_irq_mk;
   logic [CNT_W-1:0]    wd_cnt;
   tab_mode_t           wd_mode;

   // Write happens at the edge where the master sees waitrequest low
   assign wr_acc    = avs_write & ~wait_r;
   // Read data is captured one edge earlier so it stands at that edge
   assign rd_cap    = avs_read & wait_r;
   assign be_lo     = avs_byteenable[0];
   assign be_cnt    = &avs_byteenable[1:0];
   assign wr_a_cnt  = wr_acc & be_cnt & (avs_address == A_CNT_OFS);
   assign wr_a_mode = wr_acc & be_lo & (avs_address == A_MODE_OFS);
   assign wr_b_cnt  = wr_acc & be_cnt & (avs_address == B_CNT_OFS);
   assign wr_b_mode = wr_acc & be_lo & (avs_address == B_MODE_OFS);
   assign wr_start  = wr_acc & be_lo & (avs_address == START_OFS);
   assign wr_irq_st = wr_acc & be_lo & (avs_address == IRQ_ST_OFS);
   assign wr_irq_mk = wr_acc & be_lo & (avs_address == IRQ_MK_OFS);
   assign wd_cnt    = avs_writedata[CNT_W-1:0];
   assign wd_mode   = tab_mode_t'(avs_writedata[MODE_LSB+1:MODE_LSB]);

   // ---------------------------------------------------------------
   // Timer A control
   // ---------------------------------------------------------------
   logic                a_is_tmr;
   logic                a_is_evt;
   logic                a_is_osh;
   logic                a_is_pwm;
   logic                a_plain;
   logic                run_a;
   logic                step_a;
   logic                wrap_a;
   logic                rld_ev_a;
   logic                wr_halt_a;
   logic                stop_a;
   logic                os_stop;
   logic                pwm_stop;
   logic                trig_a;
   logic                os_done;
   logic                pwm_fall;
   logic                mode_irq;
   logic                load_a;
   logic [CNT_W-1:0]    load_val_a;
   logic [CNT_W-1:0]    cnt_a;
   logic                ev_a;

   assign a_is_tmr  = (mode_a_r == MODE_TMR);
   assign a_is_evt  = (mode_a_r == MODE_EVT);
   assign a_is_osh  = (mode_a_r == MODE_OSH);
   assign a_is_pwm  = (mode_a_r == MODE_PWM);
   assign a_plain   = a_is_tmr | a_is_evt;
   assign run_a     = start_a_r & (a_plain | a_is_pwm | (a_is_osh & os_act_r));
   assign step_a    = run_a & (a_is_evt ? ta_event_in : 1'b1);
   // Free-running event counter wraps without touching the reload value
   assign rld_ev_a  = wrap_a & ~(a_is_evt & free_a_r);
   assign wr_halt_a = wr_a_cnt & ~run_a;
   assign stop_a    = wr_start & ~avs_writedata[START_A] & start_a_r;
   assign os_stop   = stop_a & a_is_osh & os_act_r;
   assign pwm_stop  = stop_a & a_is_pwm;
   assign os_done   = wrap_a & a_is_osh;
   assign pwm_fall  = wrap_a & a_is_pwm & out_a_r;
   assign trig_a    = wr_start & avs_writedata[START_A]
                      & ((a_is_osh & ~os_act_r) | (a_is_pwm & ~start_a_r));
   // Reset mode is timer, so selecting either mode after reset is covered
   assign mode_irq  = wr_a_mode & a_plain
                      & ((wd_mode == MODE_OSH) | (wd_mode == MODE_PWM));
   // A halted write lands in the counter so it reads back as written
   assign load_a     = wr_halt_a | rld_ev_a | trig_a | os_stop;
   assign load_val_a = wr_halt_a ? wd_cnt : rld_a_r;
   assign ev_a       = (wrap_a & a_plain) | os_done | pwm_fall | os_stop
                       | (pwm_stop & out_a_r) | mode_irq;

   tab_cnt16 u_cnt_a (
      .clk      (clk),
      .rst_n    (rst_n),
      .ce       (ce),
      .load     (load_a),
      .load_val (load_val_a),
      .step     (step_a),
      .up       (a_is_evt & up_a_r),
      .count    (cnt_a),
      .wrap     (wrap_a)
   );

   // ---------------------------------------------------------------
   // Timer B control
   // ---------------------------------------------------------------
   logic                step_b;
   logic                wrap_b;
   logic                wr_halt_b;
   logic                load_b;
   logic [CNT_W-1:0]    cnt_b;

   // Timer B has no output pin; its wrap only raises its request
   assign step_b    = start_b_r & (evt_b_r ? tb_event_in : 1'b1);
   assign wr_halt_b = wr_b_cnt & ~start_b_r;
   assign load_b    = wr_halt_b | wrap_b;

   tab_cnt16 u_cnt_b (
      .clk      (clk),
      .rst_n    (rst_n),
      .ce       (ce),
      .load     (load_b),
      .load_val (wr_halt_b ? wd_cnt : rld_b_r),
      .step     (step_b),
      .up       (1'b0),
      .count    (cnt_b),
      .wrap     (wrap_b)
   );

   // ---------------------------------------------------------------
   // Read-back values
   // ---------------------------------------------------------------
   logic [CNT_W-1:0]    rd_a_rld;
   logic [CNT_W-1:0]    rd_a;
   logic [CNT_W-1:0]    rd_b;
   logic [DATA_W-1:0]   rd_mux;

   // In a timer or event mode reload cycle the counter is mid-update, so a fixed pattern is shown
   assign rd_a_rld = a_is_evt ? (up_a_r ? RD_ZEROS : RD_ONES) : RD_A_TMR;
   assign rd_a     = (rld_ev_a & a_plain) ? rd_a_rld : cnt_a;
   assign rd_b     = wrap_b ? RD_ONES : cnt_b;
   // Unmapped offsets read as zero
   always_comb begin
      if (avs_address == A_CNT_OFS) begin
         rd_mux = {16'h0000, rd_a};
      end else if (avs_address == A_MODE_OFS) begin
         rd_mux = {28'h0000000, up_a_r, free_a_r, mode_a_r};
      end else if (avs_address == B_CNT_OFS) begin
         rd_mux = {16'h0000, rd_b};
      end else if (avs_address == B_MODE_OFS) begin
         rd_mux = {31'h0, evt_b_r};
      end else if (avs_address == START_OFS) begin
         rd_mux = {30'h0, start_b_r, start_a_r};
      end else if (avs_address == IRQ_ST_OFS) begin
         rd_mux = {30'h0, irq_st_r};
      end else if (avs_address == IRQ_MK_OFS) begin
         rd_mux = {30'h0, irq_mk_r};
      end else if (avs_address == STAT_OFS) begin
         rd_mux = {29'h0, out_a_r, os_act_r, run_a};
      end else begin
         rd_mux = RD_UNMAPPED;
      end
   end

   // ---------------------------------------------------------------
   // Interrupt status
   // ---------------------------------------------------------------
   logic [NUM_IRQ-1:0]  irq_ev;
   logic [NUM_IRQ-1:0]  irq_clr;
   logic [NUM_IRQ-1:0]  irq_st_nxt;

   assign irq_ev     = {wrap_b, ev_a};
   assign irq_clr    = wr_irq_st ? avs_writedata[NUM_IRQ-1:0] : IRQ_RST;
   // Set beats clear; only a one written by software drops a bit
   assign irq_st_nxt = (irq_st_r & ~irq_clr) | irq_ev;

   // ---------------------------------------------------------------
   // Bus slave state
   // ---------------------------------------------------------------
   // Exactly one wait state per access; ce low stretches it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_r  <= 1'b1;
         rdata_r <= RD_UNMAPPED;
      end else if (ce) begin
         wait_r <= ~((avs_read | avs_write) & wait_r);
         if (rd_cap) begin
            rdata_r <= rd_mux;
         end
      end
   end

   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_a_r <= MODE_TMR;
         free_a_r <= 1'b0;
         up_a_r   <= 1'b0;
         evt_b_r  <= 1'b0;
         irq_mk_r <= IRQ_RST;
      end else if (ce) begin
         if (wr_a_mode) begin
            mode_a_r <= wd_mode;
            free_a_r <= avs_writedata[FREE_BIT];
            up_a_r   <= avs_writedata[UP_BIT];
         end
         if (wr_b_mode) begin
            evt_b_r <= avs_writedata[B_EVT_BIT];
         end
         if (wr_irq_mk) begin
            irq_mk_r <= avs_writedata[NUM_IRQ-1:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // Reload values
   // ---------------------------------------------------------------
   // A running counter only picks up a new value at its next reload
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rld_a_r <= CNT_RST;
         rld_b_r <= CNT_RST;
      end else if (ce) begin
         if (wr_a_cnt) begin
            rld_a_r <= wd_cnt;
         end
         if (wr_b_cnt) begin
            rld_b_r <= wd_cnt;
         end
      end
   end

   // ---------------------------------------------------------------
   // Start flags and one-shot activity
   // ---------------------------------------------------------------
   // Start flag stays set after a one-shot ends; software clears it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         start_a_r <= 1'b0;
         start_b_r <= 1'b0;
         os_act_r  <= 1'b0;
      end else if (ce) begin
         if (wr_start) begin
            start_a_r <= avs_writedata[START_A];
            start_b_r <= avs_writedata[START_B];
         end
         if (trig_a & a_is_osh) begin
            os_act_r <= 1'b1;
         end else if (os_done | os_stop | ~a_is_osh) begin
            os_act_r <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Timer A output pin
   // ---------------------------------------------------------------
   // Low in timer and event modes; pulse modes drive it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_a_r <= 1'b0;
      end else if (ce) begin
         if (trig_a) begin
            out_a_r <= 1'b1;
         end else if (os_done | os_stop | pwm_stop | a_plain) begin
            out_a_r <= 1'b0;
         end else if (wrap_a & a_is_pwm) begin
            out_a_r <= ~out_a_r;
         end
      end
   end

   // ---------------------------------------------------------------
   // Interrupt registers
   // ---------------------------------------------------------------
   // A mask write reaches the line one cycle after it lands
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_st_r <= IRQ_RST;
         irq_r    <= 1'b0;
      end else if (ce) begin
         irq_st_r <= irq_st_nxt;
         irq_r    <= |(irq_st_nxt & irq_mk_r);
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign avs_readdata       = rdata_r;
   assign avs_waitrequest    = wait_r;
   assign timer_a_output_pin = out_a_r;
   assign irq                = irq_r;

endmodule

// ==== verification/tab_timer_properties.sv ====
/* Port checker for tab_timer.
   Assumes one clock domain and async active-low reset. */
module tab_timer_chk
   import tab_pkg::*;
(
   input wire logic                       clk,
   input wire logic                       rst_n,
   input wire logic                       ce,
   input wire logic [tab_pkg::ADDR_W-1:0] avs_address,
   input wire logic                       avs_read,
   input wire logic                       avs_write,
   input wire logic [tab_pkg::DATA_W-1:0] avs_writedata,
   input wire logic [3:0]                 avs_byteenable,
   input wire logic [tab_pkg::DATA_W-1:0] avs_readdata,
   input wire logic                       avs_waitrequest,
   input wire logic                       ta_event_in,
   input wire logic                       tb_event_in,
   input wire logic                       timer_a_output_pin,
   input wire logic                       irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // -----------------
   // Shadow state
   // -----------------
   wire       acc_w = avs_write & ~avs_waitrequest & avs_byteenable[0];
   wire       osh_pwm = avs_writedata[1:0] == MODE_OSH || avs_writedata[1:0] == MODE_PWM;
   logic      mask_a_r;
   logic [1:0] mode_a_r;
   logic [2:0] clr_age_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mask_a_r <= 1'b0;
         mode_a_r <= MODE_TMR;
         clr_age_r <= 3'h7;
      end else begin
         if (acc_w && avs_address == IRQ_MK_OFS)
            mask_a_r <= avs_writedata[IRQ_A];
         if (acc_w && avs_address == A_MODE_OFS)
            mode_a_r <= avs_writedata[1:0];
         // Only a clear or a mask write may drop the line
         if (acc_w && (avs_address == IRQ_ST_OFS || avs_address == IRQ_MK_OFS))
            clr_age_r <= 3'h0;
         else if (clr_age_r != 3'h7)
            clr_age_r <= clr_age_r + 3'h1;
      end
   end
   // -----------------
   // Properties
   // -----------------
   property p_wait_ans;
      (avs_read || avs_write) && avs_waitrequest && ce |=> !avs_waitrequest;
   endproperty
   a_wait_ans: assert property (p_wait_ans) else $error("request not answered");
   property p_wait_pulse;
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
   property p_idle_wait;
      !avs_read && !avs_write |=> avs_waitrequest;
   endproperty
   a_idle_wait: assert property (p_idle_wait) else $error("waitrequest low when idle");
   property p_rd_hold;
      !avs_read |=> $stable(avs_readdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("readdata changed without read");
   property p_ce_freeze;
      !ce |=> $stable(timer_a_output_pin) && $stable(irq) && $stable(avs_waitrequest);
   endproperty
   a_ce_freeze: assert property (p_ce_freeze) else $error("outputs moved with ce low");
   property p_mode_irq;
      acc_w && avs_address == A_MODE_OFS && osh_pwm && mask_a_r
         && (mode_a_r == MODE_TMR || mode_a_r == MODE_EVT) |-> ##[1:3] irq;
   endproperty
   a_mode_irq: assert property (p_mode_irq) else $error("mode change left irq low");
   property p_fall_irq;
      $fell(timer_a_output_pin) && mask_a_r |-> ##[0:2] irq;
   endproperty
   a_fall_irq: assert property (p_fall_irq) else $error("pin fell without irq");
   property p_irq_sticky;
      $fell(irq) |-> clr_age_r <= 3'h3;
   endproperty
   a_irq_sticky: assert property (p_irq_sticky) else $error("irq dropped uncleared");
   property p_mask_off;
      acc_w && avs_address == IRQ_MK_OFS && avs_writedata[1:0] == 2'h0 |-> ##[1:2] !irq;
   endproperty
   a_mask_off: assert property (p_mask_off) else $error("irq high with all masked");
   c_mode_irq: cover property (p_mode_irq);
   c_pin_fall: cover property ($fell(timer_a_output_pin));
   c_stall: cover property (!ce && avs_read);
endmodule

bind tab_timer tab_timer_chk i_tab_timer_chk (.clk(clk), .rst_n(rst_n), .ce(ce),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .ta_event_in(ta_event_in), .tb_event_in(tb_event_in),
   .timer_a_output_pin(timer_a_output_pin), .irq(irq));

// ==== verification/timer_ab_counter_side_effects_test.sv ====
/* Self-checking bench for tab_timer.
   Assumes the bound port checker and a 250 MHz clock. */
module timer_ab_counter_side_effects_test
   import tab_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic              clk = 1'b0;
   logic              rst_n = 1'b0;
   logic              ce = 1'b1;
   logic [ADDR_W-1:0] avs_address = 5'h00;
   logic              avs_read = 1'b0;
   logic              avs_write = 1'b0;
   logic [DATA_W-1:0] avs_writedata = 32'h0;
   logic [3:0]        avs_byteenable = 4'hf;
   logic [DATA_W-1:0] avs_readdata;
   logic              avs_waitrequest;
   logic              ta_event_in = 1'b0;
   logic              tb_event_in = 1'b0;
   logic              timer_a_output_pin;
   logic              irq;
   int                n_fail = 0;
   int                n_checks = 0;
   always #2 clk = ~clk;
   tab_timer i_tab_timer (.clk(clk), .rst_n(rst_n), .ce(ce), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .ta_event_in(ta_event_in),
      .tb_event_in(tb_event_in), .timer_a_output_pin(timer_a_output_pin), .irq(irq));
   // -----------------
   // Bus and checking
   // -----------------
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= ~w;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0 && n < 50) begin
         @(posedge clk);
         n++;
      end
      if (n == 50)
         n_fail++;
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [4:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h0, q);
   endtask
   // Reads every 3 cycles against a period of 4 hit each phase
   task automatic sweep(input logic [4:0] c, m, input logic [31:0] md, input logic [15:0] rl,
                        lo, pat, input logic [31:0] go, output logic [31:0] ok);
      logic [31:0] q;
      int hits, bad;
      hits = 0;
      bad = 0;
      wr(m, md);
      wr(c, {16'h0, rl});
      wr(START_OFS, go);
      for (int i = 0; i < 9; i++) begin
         rd(c, q);
         if (q[15:0] === pat)
            hits++;
         else if (q[15:0] - lo > 16'h3)
            bad++;
      end
      wr(START_OFS, 32'h0);
      ok = 32'(hits > 0 && bad == 0);
   endtask
   // -----------------
   // Scenarios
   // -----------------
   task automatic s_written;
      logic [31:0] q;
      wr(A_CNT_OFS, 32'h1234);
      rd(A_CNT_OFS, q);
      check(q, 32'h1234);
      wr(B_CNT_OFS, 32'hbeef);
      rd(B_CNT_OFS, q);
      check(q, 32'hbeef);
      ta_event_in <= 1'b1;
      wr(A_MODE_OFS, 32'h5);
      wr(START_OFS, 32'h1);
      tick(5);
      wr(START_OFS, 32'h0);
      wr(A_CNT_OFS, 32'h0555);
      rd(A_CNT_OFS, q);
      check(q, 32'h0555);
   endtask
   task automatic s_readback;
      logic [31:0] ok;
      tb_event_in <= 1'b1;
      sweep(A_CNT_OFS, A_MODE_OFS, 32'h0, 16'h3, 16'h0, RD_A_TMR, 32'h1, ok);
      check(ok, 32'h1);
      sweep(A_CNT_OFS, A_MODE_OFS, 32'h1, 16'h3, 16'h0, RD_ONES, 32'h1, ok);
      check(ok, 32'h1);
      sweep(A_CNT_OFS, A_MODE_OFS, 32'h9, 16'hfffc, 16'hfffc, RD_ZEROS, 32'h1, ok);
      check(ok, 32'h1);
      sweep(B_CNT_OFS, B_MODE_OFS, 32'h0, 16'h3, 16'h0, RD_ONES, 32'h2, ok);
      check(ok, 32'h1);
      sweep(B_CNT_OFS, B_MODE_OFS, 32'h1, 16'h3, 16'h0, RD_ONES, 32'h2, ok);
      check(ok, 32'h1);
   endtask
   task automatic s_mode_irq;
      tab_mode_t   from[2] = '{MODE_TMR, MODE_EVT};
      tab_mode_t   to[2] = '{MODE_OSH, MODE_PWM};
      logic [31:0] q;
      wr(IRQ_MK_OFS, 32'h1);
      foreach (from[i]) foreach (to[j]) begin
         wr(A_MODE_OFS, {30'h0, from[i]});
         wr(IRQ_ST_OFS, 32'h3);
         tick(2);
         check(32'(irq), 32'h0);
         wr(A_MODE_OFS, {30'h0, to[j]});
         tick(2);
         check(32'(irq), 32'h1);
         rd(IRQ_ST_OFS, q);
         check(32'(q[IRQ_A]), 32'h1);
         wr(A_MODE_OFS, {30'h0, from[i]});
         check(32'(irq), 32'h1);
      end
      wr(IRQ_MK_OFS, 32'h0);
      tick(2);
      check(32'(irq), 32'h0);
      wr(IRQ_MK_OFS, 32'h1);
      wr(IRQ_ST_OFS, 32'h3);
      tick(2);
      check(32'(irq), 32'h0);
   endtask
   task automatic s_oneshot;
      logic [31:0] q;
      wr(A_MODE_OFS, {30'h0, MODE_OSH});
      wr(A_CNT_OFS, 32'h0800);
      wr(IRQ_ST_OFS, 32'h3);
      wr(START_OFS, 32'h1);
      tick(3);
      rd(STAT_OFS, q);
      check(q, 32'h7);
      wr(START_OFS, 32'h0);
      tick(1);
      check(32'(timer_a_output_pin), 32'h0);
      check(32'(irq), 32'h1);
      rd(A_CNT_OFS, q);
      check(q, 32'h0800);
      rd(STAT_OFS, q);
      check(q, 32'h0);
   endtask
   task automatic s_pwm;
      int n;
      wr(A_MODE_OFS, {30'h0, MODE_PWM});
      wr(A_CNT_OFS, 32'h0010);
      wr(IRQ_ST_OFS, 32'h3);
      wr(START_OFS, 32'h1);
      check(32'(timer_a_output_pin), 32'h1);
      wr(START_OFS, 32'h0);
      tick(1);
      check(32'(timer_a_output_pin), 32'h0);
      check(32'(irq), 32'h1);
      wr(IRQ_ST_OFS, 32'h3);
      wr(START_OFS, 32'h1);
      n = 0;
      while (timer_a_output_pin !== 1'b0 && n < 60) begin
         tick(1);
         n++;
      end
      // Low half lasts 17 cycles: clear and stop fit inside it
      wr(IRQ_ST_OFS, 32'h3);
      wr(START_OFS, 32'h0);
      tick(2);
      check(32'(n < 60), 32'h1);
      check(32'(timer_a_output_pin), 32'h0);
      check(32'(irq), 32'h0);
   endtask
   task automatic s_stall;
      logic [31:0] q;
      rd(5'h01, q);
      check(q, RD_UNMAPPED);
      ce <= 1'b0;
      fork
         rd(A_MODE_OFS, q);
         begin
            tick(4);
            check(32'(avs_waitrequest), 32'h1);
            ce <= 1'b1;
         end
      join
      check(q, {30'h0, MODE_PWM});
   endtask
   // -----------------
   // Run control
   // -----------------
   task automatic wrap_up;
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #40000;
      n_fail++;
      wrap_up;
   end
   initial begin
      tick(8);
      rst_n <= 1'b1;
      tick(1);
      check(32'(irq), 32'h0);
      s_written;
      s_readback;
      s_mode_irq;
      s_oneshot;
      s_pwm;
      s_stall;
      wrap_up;
   end
endmodule
